/* File: core/rsm_pkg.sv */
// package: constants for the receive and sync interrupt mask block
package rsm_pkg;
  localparam int          NUM_FRAMERS   = 8;
  localparam int          NUM_COUNTERS  = 7;
  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 12;
  localparam int          CODE_W        = 7;
  localparam int          MSG_W         = 17;
  localparam int          CAS_W         = 4;
  localparam int          HIST_DEPTH    = 10;
  localparam int          HIST_NEEDED   = 8;
  localparam int          CNT_W         = 4;

  // framer select in addr[11:8], register offset in addr[7:0]
  localparam int          SEL_LSB       = 8;
  localparam logic [3:0]  SEL_BROADCAST = 4'h8;
  localparam logic [7:0]  RX_SYNC_IRQ_MASK_OFFSET = 8'h44;
  localparam logic [15:0] RX_SYNC_IRQ_MASK_RESET  = 16'h0000;
  localparam logic [15:0] READ_IDLE     = 16'h0000;

  // counter overflow: value goes from all ones to zero
  localparam logic [7:0]  CTR_MAX       = 8'hFF;
  localparam logic [7:0]  CTR_ZERO      = 8'h00;

  // counter index within the packed counter inputs
  localparam int CTR_FBE    = 0;
  localparam int CTR_CRC    = 1;
  localparam int CTR_OOF    = 2;
  localparam int CTR_COFA   = 3;
  localparam int CTR_BPV    = 4;
  localparam int CTR_PRBS   = 5;
  localparam int CTR_PRBSMF = 6;

  // mask bit positions; counter masks sit at 15 - counter index
  localparam int BIT_CTR_TOP      = 15;
  localparam int BIT_MF_OOS_OVF   = 8;
  localparam int BIT_TERM_SYNC    = 7;
  localparam int BIT_MF_SYNC      = 6;
  localparam int BIT_FBIT_ERR     = 5;
  localparam int BIT_MSG_RX       = 4;
  localparam int BIT_MSG_MATCH    = 3;
  localparam int BIT_SIG_CHANGE   = 2;
  localparam int BIT_ONE_SEC      = 1;
  localparam int BIT_TWO_SEC      = 0;

  // message frame 111111110xxxxxxx0: header ones, a zero, code, a zero
  localparam logic [7:0] MSG_HEAD     = 8'hFF;
  localparam int         MSG_HEAD_LSB = 9;
  localparam int         MSG_SEP_BIT  = 8;
  localparam int         MSG_CODE_LSB = 1;
  localparam int         MSG_TAIL_BIT = 0;
endpackage

/* File: core/rsm_bom_if.sv */
// interface: message position hand-off between top and one validator
`timescale 1ns/1ps
interface rsm_bom_if;
  logic                       msgStrobe;
  logic [rsm_pkg::MSG_W-1:0]  msgWord;
  logic [rsm_pkg::CODE_W-1:0] matchCode;
  logic                       newMsg;
  logic                       newMatch;

  modport src (output msgStrobe, output msgWord, output matchCode,
               input newMsg, input newMatch);
  modport dst (input msgStrobe, input msgWord, input matchCode,
               output newMsg, output newMatch);
endinterface

/* File: core/rsm_bom_validator.sv */
// module: persistence filter for bit oriented messages of one framer
`timescale 1ns/1ps
module rsm_bom_validator (
  input  wire logic clock,   // core clock
  input  wire logic rst,     // synchronous reset, active high
  input  wire logic ce,      // clock enable
  rsm_bom_if.dst    bom      // message positions in, events out
);
  logic [rsm_pkg::CODE_W-1:0] histCode_reg [rsm_pkg::HIST_DEPTH];
  logic [rsm_pkg::HIST_DEPTH-1:0] histOk_reg;
  logic [rsm_pkg::CODE_W-1:0] lastCode_reg;
  logic                       haveLast_reg;
  logic                       patternOk;
  logic [rsm_pkg::CODE_W-1:0] code;
  logic [rsm_pkg::CNT_W-1:0]  hits;
  logic                       accept;

  // a position with the wrong framing is not counted toward any code
  assign patternOk =
    (bom.msgWord[rsm_pkg::MSG_W-1:rsm_pkg::MSG_HEAD_LSB]
       == rsm_pkg::MSG_HEAD) &&
    !bom.msgWord[rsm_pkg::MSG_SEP_BIT] &&
    !bom.msgWord[rsm_pkg::MSG_TAIL_BIT];
  assign code = bom.msgWord[rsm_pkg::MSG_SEP_BIT-1:rsm_pkg::MSG_CODE_LSB];

  // count the new position plus the nine before it holding this code
  always_comb begin
    hits = patternOk ? rsm_pkg::CNT_W'(1) : '0;
    for (int i = 0; i < rsm_pkg::HIST_DEPTH - 1; i++) begin
      if (patternOk && histOk_reg[i] && histCode_reg[i] == code) begin
        hits = hits + rsm_pkg::CNT_W'(1);
      end
    end
  end

  assign accept = bom.msgStrobe && patternOk &&
                  hits >= rsm_pkg::CNT_W'(rsm_pkg::HIST_NEEDED) &&
                  (!haveLast_reg || code != lastCode_reg);

  always_ff @(posedge clock) begin
    if (rst) begin
      histOk_reg <= '0;
      for (int i = 0; i < rsm_pkg::HIST_DEPTH; i++) begin
        histCode_reg[i] <= '0;
      end
    end else if (ce && bom.msgStrobe) begin
      histOk_reg <= {histOk_reg[rsm_pkg::HIST_DEPTH-2:0], patternOk};
      histCode_reg[0] <= code;
      for (int i = 1; i < rsm_pkg::HIST_DEPTH; i++) begin
        histCode_reg[i] <= histCode_reg[i-1];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lastCode_reg <= '0;
      haveLast_reg <= 1'b0;
    end else if (ce && accept) begin
      lastCode_reg <= code;
      haveLast_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bom.newMsg   <= 1'b0;
      bom.newMatch <= 1'b0;
    end else if (ce) begin
      bom.newMsg   <= accept;
      bom.newMatch <= accept && code == bom.matchCode;
    end
  end
endmodule // rsm_bom_validator

/* File: core/rsm_rx_sync_irq_mask.sv */
// module: per-framer receive and sync interrupt masking, eight framers
`timescale 1ns/1ps

module rsm_rx_sync_irq_mask (
  input  wire logic        clock,          // core clock, 250 MHz
  input  wire logic        rst,            // hard reset, sync, high
  input  wire logic        ce,             // clock enable
  input  wire logic        softRst,        // software reset pulse
  input  wire logic        lineTypeWr,     // global line-type write
  input  wire logic [rsm_pkg::ADDR_W-1:0] addr, // micro port address
  input  wire logic        wrEn,           // write strobe
  input  wire logic        rdEn,           // read strobe
  input  wire logic [rsm_pkg::DATA_W-1:0] wrData, // write data
  output logic      [rsm_pkg::DATA_W-1:0] rdData, // read data, registered
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0]
                    [rsm_pkg::NUM_COUNTERS-1:0][7:0] ctrValue, // counters
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0]
                    [7:0]  mfOosCount,     // multiframe out of sync count
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] termSyncLoss, // level
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] mfSyncLoss,   // level
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] fbitErr,      // pulse
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] msgStrobe,    // pulse
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0]
                    [rsm_pkg::MSG_W-1:0] msgWord,  // message position
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0]
                    [rsm_pkg::CODE_W-1:0] matchCode, // match register
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] casSample,    // pulse
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0]
                    [rsm_pkg::CAS_W-1:0] casBits,  // received signaling
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] signalingDebounceEnable,
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] oneSecStatus, // level
  input  wire logic [rsm_pkg::NUM_FRAMERS-1:0] twoSecStatus, // level
  output logic      [rsm_pkg::NUM_FRAMERS-1:0] irqReq        // registered
);
  localparam int NF = rsm_pkg::NUM_FRAMERS;
  localparam int NC = rsm_pkg::NUM_COUNTERS;
  localparam int DW = rsm_pkg::DATA_W;

  logic [DW-1:0]              mask_reg     [NF];
  logic [NC-1:0][7:0]         ctrPrev_reg  [NF];
  logic [7:0]                 mfOosPrev_reg[NF];
  logic [rsm_pkg::CAS_W-1:0]  casCand_reg  [NF];
  logic [rsm_pkg::CAS_W-1:0]  casStable_reg[NF];
  logic [NF-1:0]              casPrimed_reg;
  logic [NF-1:0]              casChange_reg;
  logic [NF-1:0]              oneSecPrev_reg;
  logic [NF-1:0]              twoSecPrev_reg;
  logic [DW-1:0]              event_w      [NF];
  logic [NF-1:0]              irqReq_next;
  logic [3:0]                 sel;
  logic                       offsetHit;
  logic [NF-1:0]              wrSel;
  logic [DW-1:0]              rdData_next;
  logic                       maskClear;

  rsm_bom_if bomIf [NF] ();

  assign sel       = addr[rsm_pkg::ADDR_W-1:rsm_pkg::SEL_LSB];
  assign offsetHit = addr[rsm_pkg::SEL_LSB-1:0]
                     == rsm_pkg::RX_SYNC_IRQ_MASK_OFFSET;
  assign maskClear = softRst || lineTypeWr;

  // framer select decode; broadcast code reaches every copy
  always_comb begin
    wrSel = '0;
    if (wrEn && offsetHit) begin
      if (sel == rsm_pkg::SEL_BROADCAST) begin
        wrSel = '1;
      end else if (sel < 4'(NF)) begin
        wrSel[sel[2:0]] = 1'b1;
      end
    end
  end

  // mask copies; a reset source outranks a write in the same cycle
  always_ff @(posedge clock) begin
    for (int f = 0; f < NF; f++) begin
      if (rst) begin
        mask_reg[f] <= rsm_pkg::RX_SYNC_IRQ_MASK_RESET;
      end else if (ce) begin
        if (maskClear) begin
          mask_reg[f] <= rsm_pkg::RX_SYNC_IRQ_MASK_RESET;
        end else if (wrSel[f]) begin
          mask_reg[f] <= wrData;
        end
      end
    end
  end

  // readback; unmapped offsets and framer codes read as zero
  always_comb begin
    rdData_next = rsm_pkg::READ_IDLE;
    if (offsetHit && sel < 4'(NF)) begin
      rdData_next = mask_reg[sel[2:0]];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData <= rsm_pkg::READ_IDLE;
    end else if (ce && rdEn) begin
      rdData <= rdData_next;
    end
  end

  // previous counter values for wrap detection
  always_ff @(posedge clock) begin
    for (int f = 0; f < NF; f++) begin
      if (rst) begin
        ctrPrev_reg[f]   <= '0;
        mfOosPrev_reg[f] <= rsm_pkg::CTR_ZERO;
      end else if (ce) begin
        ctrPrev_reg[f]   <= ctrValue[f];
        mfOosPrev_reg[f] <= mfOosCount[f];
      end
    end
  end

  // signaling debounce: a new pattern must be seen on two samples
  // running when enabled; costs one sample of latency, avoids chatter
  always_ff @(posedge clock) begin
    for (int f = 0; f < NF; f++) begin
      if (rst) begin
        casCand_reg[f]   <= '0;
        casStable_reg[f] <= '0;
        casPrimed_reg[f] <= 1'b0;
        casChange_reg[f] <= 1'b0;
      end else if (ce) begin
        casChange_reg[f] <= 1'b0;
        if (casSample[f]) begin
          casCand_reg[f] <= casBits[f];
          if (!casPrimed_reg[f]) begin
            // first sample after reset seeds the state without an event
            casStable_reg[f] <= casBits[f];
            casPrimed_reg[f] <= 1'b1;
          end else if (casBits[f] != casStable_reg[f] &&
                       (!signalingDebounceEnable[f] ||
                        casBits[f] == casCand_reg[f])) begin
            casStable_reg[f] <= casBits[f];
            casChange_reg[f] <= 1'b1;
          end
        end
      end
    end
  end

  // timer status edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      oneSecPrev_reg <= '0;
      twoSecPrev_reg <= '0;
    end else if (ce) begin
      oneSecPrev_reg <= oneSecStatus;
      twoSecPrev_reg <= twoSecStatus;
    end
  end

  // per-framer message validators and event vectors
  for (genvar g = 0; g < NF; g++) begin : gFramer
    assign bomIf[g].msgStrobe = msgStrobe[g];
    assign bomIf[g].msgWord   = msgWord[g];
    assign bomIf[g].matchCode = matchCode[g];

    rsm_bom_validator uValidator (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .bom   (bomIf[g])
    );

    always_comb begin
      event_w[g] = '0;
      for (int c = 0; c < NC; c++) begin
        event_w[g][rsm_pkg::BIT_CTR_TOP-c] =
          ctrPrev_reg[g][c] == rsm_pkg::CTR_MAX &&
          ctrValue[g][c] == rsm_pkg::CTR_ZERO;
      end
      event_w[g][rsm_pkg::BIT_MF_OOS_OVF] =
        mfOosPrev_reg[g] == rsm_pkg::CTR_MAX &&
        mfOosCount[g] == rsm_pkg::CTR_ZERO;
      event_w[g][rsm_pkg::BIT_TERM_SYNC]  = termSyncLoss[g];
      event_w[g][rsm_pkg::BIT_MF_SYNC]    = mfSyncLoss[g];
      event_w[g][rsm_pkg::BIT_FBIT_ERR]   =
        fbitErr[g] && !termSyncLoss[g];
      event_w[g][rsm_pkg::BIT_MSG_RX]     = bomIf[g].newMsg;
      event_w[g][rsm_pkg::BIT_MSG_MATCH]  = bomIf[g].newMatch;
      event_w[g][rsm_pkg::BIT_SIG_CHANGE] = casChange_reg[g];
      event_w[g][rsm_pkg::BIT_ONE_SEC]    =
        oneSecStatus[g] && !oneSecPrev_reg[g];
      event_w[g][rsm_pkg::BIT_TWO_SEC]    =
        twoSecStatus[g] && !twoSecPrev_reg[g];
    end

    assign irqReq_next[g] = |(event_w[g] & ~mask_reg[g]);
  end

  // request is registered, one cycle after its cause; two after a message or signaling strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      irqReq <= '0;
    end else if (ce) begin
      irqReq <= irqReq_next;
    end
  end
endmodule // rsm_rx_sync_irq_mask

/* File: verif/rsm_rx_sync_irq_mask_asserts.sv */
// checker: mask register and request relations at the block ports
`timescale 1ns/1ps
module rsm_rx_sync_irq_mask_asserts (
  input wire logic                  clock,        // core clock
  input wire logic                  rst,          // hard reset
  input wire logic                  ce,           // clock enable
  input wire logic                  softRst,      // software reset
  input wire logic                  lineTypeWr,   // line-type write
  input wire logic [11:0]           addr,         // address
  input wire logic                  wrEn,         // write strobe
  input wire logic                  rdEn,         // read strobe
  input wire logic [15:0]           wrData,       // write data
  input wire logic [15:0]           rdData,       // read data
  input wire logic [7:0][6:0][7:0]  ctrValue,     // counters
  input wire logic [7:0][7:0]       mfOosCount,   // mf out of sync count
  input wire logic [7:0]            termSyncLoss, // terminal sync lost
  input wire logic [7:0]            mfSyncLoss,   // multiframe sync lost
  input wire logic [7:0]            fbitErr,      // framing bit error
  input wire logic [7:0]            oneSecStatus, // one second level
  input wire logic [7:0]            twoSecStatus, // two second level
  input wire logic [7:0]            irqReq        // requests
);
  // shadow copy of every framer mask, rebuilt from port traffic
  logic [7:0][15:0] msk;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock)
    if (rst || (ce && (softRst || lineTypeWr)))
      msk <= '0;
    else if (ce && wrEn && addr[7:0] == 8'h44)
      for (int f = 0; f < 8; f++)
        if (addr[11:8] == f || addr[11:8] == 4'h8)
          msk[f] <= wrData;
  sequence sClearThenRead;
    ce && softRst ##1 ce && rdEn && !wrEn && addr[7:0] == 8'h44 && !addr[11];
  endsequence
  AST_SOFT_CLR: assert property (sClearThenRead |=> rdData == 16'h0000)
    else $error("mask read after soft reset not zero");
  AST_RD_OFF: assert property (ce && rdEn && addr[7:0] != 8'h44
    |=> rdData == 16'h0000) else $error("unmapped read not zero");
  for (genvar f = 0; f < 8; f++) begin : g_fr
    for (genvar c = 0; c < 7; c++) begin : g_ct
      AST_CTR_WRAP: assert property (ce && $past(ce) && !$past(rst)
        && $past(ctrValue[f][c]) == 8'hFF && ctrValue[f][c] == 8'h00
        && !msk[f][15-c] |=> irqReq[f]) else $error("counter wrap lost");
    end
    AST_MF_OOS: assert property (ce && $past(ce) && !$past(rst)
      && $past(mfOosCount[f]) == 8'hFF && mfOosCount[f] == 8'h00
      && !msk[f][8] |=> irqReq[f]) else $error("mf count wrap lost");
    AST_TERM_SYNC: assert property (ce && termSyncLoss[f] && !msk[f][7]
      |=> irqReq[f]) else $error("terminal sync loss not raised");
    AST_MF_SYNC: assert property ((ce && mfSyncLoss[f] && !msk[f][6])[*2]
      |=> irqReq[f]) else $error("multiframe sync loss not held");
    AST_FBIT: assert property (ce && fbitErr[f] && !termSyncLoss[f]
      && !msk[f][5] |=> irqReq[f]) else $error("framing bit error lost");
    AST_ONE_SEC: assert property (ce && $past(ce) && !$past(rst)
      && $rose(oneSecStatus[f]) && !msk[f][1] |=> irqReq[f])
      else $error("one second edge lost");
    AST_TWO_SEC: assert property (ce && $past(ce) && !$past(rst)
      && $rose(twoSecStatus[f]) && !msk[f][0] |=> irqReq[f])
      else $error("two second edge lost");
    AST_QUIET: assert property (ce && $past(ce) && msk[f] == 16'hFFFF
      && $past(msk[f]) == 16'hFFFF |=> !irqReq[f])
      else $error("request while fully masked");
    AST_RD_MASK: assert property (ce && rdEn && !wrEn && !softRst
      && !lineTypeWr && addr[11:8] == f && addr[7:0] == 8'h44
      |=> rdData == $past(msk[f])) else $error("mask read mismatch");
  end
endmodule // rsm_rx_sync_irq_mask_asserts

bind rsm_rx_sync_irq_mask rsm_rx_sync_irq_mask_asserts
  rsm_rx_sync_irq_mask_asserts_i (.clock, .rst, .ce, .softRst, .lineTypeWr,
  .addr, .wrEn, .rdEn, .wrData, .rdData, .ctrValue, .mfOosCount,
  .termSyncLoss, .mfSyncLoss, .fbitErr, .oneSecStatus, .twoSecStatus,
  .irqReq);

/* File: verif/rsm_rx_sync_irq_mask_bench.sv */
// testbench: mask register access and per-event masking of framer 0
`timescale 1ns/1ps
module rsm_rx_sync_irq_mask_bench;
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic                  ce = 1'b1;
  logic                  softRst = 1'b0;
  logic                  lineTypeWr = 1'b0;
  logic [11:0]           addr = 12'h000;
  logic                  wrEn = 1'b0;
  logic                  rdEn = 1'b0;
  logic [15:0]           wrData = 16'h0000;
  logic [15:0]           rdData;
  logic [7:0][6:0][7:0]  ctrValue = '0;
  logic [7:0][7:0]       mfOosCount = '0;
  logic [7:0]            termSyncLoss = '0, mfSyncLoss = '0, fbitErr = '0;
  logic [7:0]            msgStrobe = '0, casSample = '0, irqReq;
  logic [7:0][16:0]      msgWord = '0;
  logic [7:0][6:0]       matchCode = '0;
  logic [7:0][3:0]       casBits = '0;
  logic [7:0]            signalingDebounceEnable = '0;
  logic [7:0]            oneSecStatus = '0, twoSecStatus = '0;
  int                    bad_count = 0;
  int                    checked = 0;
  int                    bits[5] = '{7, 6, 5, 1, 0};

  rsm_rx_sync_irq_mask rsm_rx_sync_irq_mask_i (.clock, .rst, .ce, .softRst,
    .lineTypeWr, .addr, .wrEn, .rdEn, .wrData, .rdData, .ctrValue,
    .mfOosCount, .termSyncLoss, .mfSyncLoss, .fbitErr, .msgStrobe, .msgWord,
    .matchCode, .casSample, .casBits, .signalingDebounceEnable,
    .oneSecStatus, .twoSecStatus, .irqReq);

  always #2 clock = ~clock;

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cyc(input int n = 1);
    repeat (n) @(negedge clock);
  endtask
  task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected read at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cmp_irq(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected request at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    cyc();
    wrEn = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [15:0] exp);
    addr = a;
    rdEn = 1'b1;
    cyc();
    rdEn = 1'b0;
    cmp_reg(rdData, exp);
  endtask
  task t_regs;
    for (int f = 0; f < 8; f++)
      rd({f[3:0], 8'h44}, 16'h0000);
    wr(12'h344, 16'h0010);
    rd(12'h344, 16'h0010);
    wr(12'h844, 16'hA5A5);
    for (int f = 0; f < 8; f++)
      rd({f[3:0], 8'h44}, 16'hA5A5);
    wr(12'h045, 16'hFFFF);
    rd(12'h045, 16'h0000);
    rd(12'h044, 16'hA5A5);
    rd(12'h844, 16'h0000);
  endtask
  task t_clear;
    wr(12'h844, 16'hFFFF);
    cyc(2);
    softRst = 1'b1;
    cyc();
    softRst = 1'b0;
    rd(12'h144, 16'h0000);
    wr(12'h844, 16'hFFFF);
    lineTypeWr = 1'b1;
    cyc();
    lineTypeWr = 1'b0;
    rd(12'h744, 16'h0000);
  endtask
  // two wraps per counter, unmasked then masked; index 7 is the mf count
  task t_ctr;
    for (int c = 0; c < 8; c++)
      for (int m = 0; m < 2; m++) begin
        wr(12'h044, {15'h0000, m[0]} << (c < 7 ? 15 - c : 8));
        if (c < 7) ctrValue[0][c] = 8'hFF; else mfOosCount[0] = 8'hFF;
        cyc();
        if (c < 7) ctrValue[0][c] = 8'h00; else mfOosCount[0] = 8'h00;
        cyc();
        cmp_irq(irqReq[0], !m[0]);
        cyc();
        cmp_irq(irqReq[0], 1'b0);
      end
  endtask
  task drv(input int b, input logic v);
    case (b)
      7: termSyncLoss[0] = v;
      6: mfSyncLoss[0] = v;
      5: fbitErr[0] = v;
      1: oneSecStatus[0] = v;
      default: twoSecStatus[0] = v;
    endcase
  endtask
  task t_evt;
    foreach (bits[i])
      for (int m = 0; m < 2; m++) begin
        wr(12'h044, {15'h0000, m[0]} << bits[i]);
        drv(bits[i], 1'b1);
        cyc();
        cmp_irq(irqReq[0], !m[0]);
        cyc();
        drv(bits[i], 1'b0);
        cyc();
        cmp_irq(irqReq[0], 1'b0);
      end
    wr(12'h044, 16'h0080);
    termSyncLoss[0] = 1'b1;
    cyc();
    fbitErr[0] = 1'b1;
    cyc();
    fbitErr[0] = 1'b0;
    cmp_irq(irqReq[0], 1'b0);
    termSyncLoss[0] = 1'b0;
  endtask
  task samp(input logic [3:0] v, input logic exp);
    casBits[0] = v;
    casSample[0] = 1'b1;
    cyc();
    casSample[0] = 1'b0;
    cyc();
    cmp_irq(irqReq[0], exp);
  endtask
  task t_cas;
    wr(12'h044, 16'h0000);
    samp(4'h3, 1'b0);
    samp(4'h3, 1'b0);
    samp(4'h5, 1'b1);
    wr(12'h044, 16'h0004);
    samp(4'h6, 1'b0);
    wr(12'h044, 16'h0000);
    signalingDebounceEnable[0] = 1'b1;
    samp(4'h9, 1'b0);
    samp(4'h9, 1'b1);
  endtask
  // eight framed positions of one code; only the eighth may be accepted
  task msg(input logic [6:0] code, input logic exp);
    for (int i = 0; i < 8; i++) begin
      msgWord[0] = {8'hFF, 1'b0, code, 1'b0};
      msgStrobe[0] = 1'b1;
      cyc();
      msgStrobe[0] = 1'b0;
      cyc();
      cmp_irq(irqReq[0], exp && i == 7);
    end
  endtask
  task t_msg;
    matchCode[0] = 7'h55;
    wr(12'h044, 16'h0008);
    msg(7'h12, 1'b1);
    msg(7'h12, 1'b0);
    wr(12'h044, 16'h0010);
    msg(7'h55, 1'b1);
    msg(7'h23, 1'b0);
  endtask

  initial begin
    #20000;
    bad_count++;
    $display("unexpected hang at %0t: got %h want %h", $time, 1'b0, 1'b1);
    print_verdict();
  end
  initial begin
    cyc(12);
    rst = 1'b0;
    t_regs();
    t_clear();
    t_ctr();
    t_evt();
    t_cas();
    t_msg();
    print_verdict();
  end
endmodule // rsm_rx_sync_irq_mask_bench
